// ===== rtl/lpsd_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module lpsd_ctrl
  import lpsd_pkg::*;
#(
  parameter int REF_CYC = LPSD_TREF_CYC,
  parameter int DPD_CYC = LPSD_DPD_CYC,
  parameter int DPDX_CYC = LPSD_DPDX_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // User request: one-cycle pulses with bank, address
  input wire logic req_i,
  input wire logic [3:0] req_cmd_i,
  input wire logic [1:0] req_ba_i,
  input wire logic [12:0] req_addr_i,
  input wire logic [3:0] req_dqm_i,
  input wire logic [31:0] req_data_i,
  input wire logic req_cke_i,
  output logic req_ready_o,
  // Read data back
  output logic [31:0] rd_data_o,
  output logic rd_valid_o,
  // Link to the device
  lpsd_if.ctrl mem
);
  // Timers count up to these; zero would never expire
  if (REF_CYC < 2 || DPD_CYC < 1 || DPDX_CYC < 1) begin : g_bad_counts
    $error("lpsd_ctrl: counts must be positive");
  end

  typedef enum logic [2:0] {
    LPSD_C_RUN = 3'h0,
    LPSD_C_LOW = 3'h1,
    LPSD_C_DPD = 3'h3,
    LPSD_C_WAKE = 3'h2,
    LPSD_C_XSR = 3'h6
  } lpsd_ctl_type;

  lpsd_ctl_type st_ff;
  logic [31:0] cnt_ff;
  logic [1:0] nops_ff;
  logic sref_ff;
  logic [1:0] oe_sync_ff;
  logic [31:0] rd_s1_ff;
  logic [31:0] rd_s2_ff;

  // Timer per low-power phase; waking phases refuse user commands
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= LPSD_C_RUN;
      cnt_ff <= '0;
      nops_ff <= '0;
      sref_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        LPSD_C_RUN: if (req_i && !req_cke_i) begin
          st_ff <= LPSD_C_LOW;
          cnt_ff <= '0;
          sref_ff <= (req_cmd_i == LPSD_CMD_REF); // see R20
        end
        LPSD_C_LOW: begin
          cnt_ff <= cnt_ff + 32'h1;
          if (req_i && !sref_ff && req_cmd_i == LPSD_CMD_BST) begin
            st_ff <= LPSD_C_DPD; // see R15
            cnt_ff <= '0;
          end else if (!sref_ff && cnt_ff >= 32'(REF_CYC - 2)) begin
            st_ff <= sref_ff ? LPSD_C_XSR : LPSD_C_RUN; // see R5
          end else if (req_i && req_cke_i) begin
            st_ff <= sref_ff ? LPSD_C_XSR : LPSD_C_RUN; // see R6
            cnt_ff <= '0;
            nops_ff <= '0;
          end
        end
        LPSD_C_DPD: begin
          cnt_ff <= cnt_ff + 32'h1;
          if (req_i && req_cke_i && cnt_ff >= 32'(DPD_CYC - 1)) begin // see R15
            st_ff <= LPSD_C_WAKE;
            cnt_ff <= '0;
          end
        end
        LPSD_C_WAKE: begin
          // NOPs for the wake time; user then runs the init sequence
          cnt_ff <= cnt_ff + 32'h1;
          if (cnt_ff >= 32'(DPDX_CYC - 1)) st_ff <= LPSD_C_RUN; // see R16
        end
        LPSD_C_XSR: begin
          cnt_ff <= cnt_ff + 32'h1;
          if (nops_ff != 2'(LPSD_MIN_XSR_NOPS)) nops_ff <= nops_ff + 2'h1;
          if (cnt_ff >= 32'(LPSD_TXSR_CYC - 1) && nops_ff == 2'(LPSD_MIN_XSR_NOPS)) st_ff <= LPSD_C_RUN; // see R17
        end
        default: st_ff <= LPSD_C_RUN;
      endcase
    end
  end

  logic run;
  assign run = (st_ff == LPSD_C_RUN);
  // Deep power down takes no wake request before its minimum stay
  assign req_ready_o = run || st_ff == LPSD_C_LOW || (st_ff == LPSD_C_DPD && cnt_ff >= 32'(DPD_CYC - 1)); // see R15

  // Drive pins from flops; NOP whenever nothing is issued
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem.cke <= 1'b1;
      {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= LPSD_CMD_INH;
      mem.ba <= '0;
      mem.addr <= '0;
      mem.dqm <= '0;
      mem.dq_ctl <= '0;
      mem.dq_ctl_oe <= 1'b0;
    end else begin
      {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= LPSD_CMD_NOP;
      mem.dq_ctl_oe <= 1'b0;
      mem.dqm <= req_dqm_i; // see R12
      if (st_ff == LPSD_C_WAKE || st_ff == LPSD_C_XSR) mem.cke <= 1'b1;
      else if (st_ff == LPSD_C_LOW && !sref_ff && cnt_ff >= 32'(REF_CYC - 2)) mem.cke <= 1'b1; // see R5
      if (req_i && req_ready_o) begin
        mem.cke <= req_cke_i;
        mem.ba <= req_ba_i;
        mem.addr <= req_addr_i; // see R1
        mem.dq_ctl <= req_data_i;
        mem.dq_ctl_oe <= (req_cmd_i == LPSD_CMD_WR);
        // Leaving a low state only with NOP; DPD entry keeps CKE low
        if (run || req_cmd_i == LPSD_CMD_BST) {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= req_cmd_i; // see R18
      end
    end
  end

  // Returned data crosses from pins through three flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_s1_ff <= '0;
      rd_s2_ff <= '0;
      oe_sync_ff <= '0;
      rd_data_o <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_s1_ff <= mem.dq_mem;
      rd_s2_ff <= rd_s1_ff;
      oe_sync_ff <= {oe_sync_ff[0], mem.dq_mem_oe};
      rd_valid_o <= oe_sync_ff[1];
      rd_data_o <= rd_s2_ff;
    end
  end
endmodule : lpsd_ctrl
`default_nettype wire

// ===== rtl/lpsd_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lpsd_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  logic [3:0] dqm;
  logic [31:0] dq_ctl;
  logic dq_ctl_oe;
  logic [31:0] dq_mem;
  logic dq_mem_oe;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl, dq_ctl_oe, input dq_mem, dq_mem_oe);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl, dq_ctl_oe, output dq_mem, dq_mem_oe);
endinterface : lpsd_if
`default_nettype wire

// ===== rtl/lpsd_mem.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1 - Precharge one bank, or all when flagged
// R2 - Activate a precharged bank before access
// R3 - CKE low with NOP idle: power-down
// R4 - Buffers off in power-down except CKE
// R5 - Power-down shorter than the refresh period
// R6 - CKE high with NOP exits power-down
// R7 - CKE low during burst suspends next edge
// R8 - Suspended edge: ignore inputs, hold outputs
// R9 - CKE high resumes, next command accepted
// R10 - Write burst mode bit forces single writes
// R11 - Read cuts auto-precharge read, precharges it
// R12 - Write cuts auto-precharge read; early DQM
// R13 - Read cuts auto-precharge write after recovery
// R14 - Write cuts auto-precharge write after recovery
// R15 - Burst stop with CKE low: deep power down
// R16 - Deep power down exit init sequence
// R17 - Self refresh exit: NOPs until tXSR
// R18 - Command decode from four strobes
// R19 - Refresh and mode load need all idle
// R20 - CKE falling with refresh: self refresh
module lpsd_mem
  import lpsd_pkg::*;
#(
  parameter int BANKS = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Link to the controller
  lpsd_if.mem mem,
  // Observed state
  output logic [BANKS-1:0] bank_open_o,
  output logic [BANKS-1:0] bank_pre_o,
  output logic [2:0] pwr_state_o,
  output logic in_buf_en_o,
  output logic [31:0] wr_data_o,
  output logic [1:0] wr_bank_o,
  output logic wr_valid_o
);
  // Bank decode and the read pattern assume four banks
  if (BANKS != 4) begin : g_bad_banks
    $error("lpsd_mem: BANKS must be 4");
  end

  lpsd_pwr_type pwr_ff;
  lpsd_pwr_type nxt_pwr;
  logic cke_q_ff;
  logic [12:0] mode_ff;
  logic [BANKS-1:0] open_ff;
  logic [BANKS-1:0] ap_ff;
  logic [BANKS-1:0] pre_pend_ff;
  logic [3:0] pre_cnt_ff [BANKS];
  logic [3:0] cmd;
  logic busy_ff;
  logic rd_ff;
  logic [3:0] burst_ff;
  logic [1:0] burst_bank_ff;
  logic [31:0] rd_data_ff [4];
  logic [3:0] rd_lat_ff;
  logic [31:0] dq_out_ff;
  logic dq_oe_ff;

  // Strobes to command code; chip select high is inhibit
  function automatic logic [3:0] decode(input logic cs_n, ras_n, cas_n, we_n);
    decode = cs_n ? LPSD_CMD_INH : {1'b0, ras_n, cas_n, we_n}; // see R18
  endfunction

  function automatic logic [3:0] burst_len(input logic [2:0] bl);
    burst_len = (bl == 3'h0) ? 4'h1 : (bl == 3'h1) ? 4'h2 : (bl == 3'h2) ? 4'h4 : 4'h8;
  endfunction

  logic suspended;
  logic is_nop;
  logic all_idle;
  assign cmd = decode(mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n);
  assign is_nop = (cmd == LPSD_CMD_NOP) || (cmd == LPSD_CMD_INH);
  assign all_idle = (open_ff == '0) && (pre_pend_ff == '0);
  // Suspend only applies while a burst runs and the device is awake
  assign suspended = (pwr_ff == LPSD_ST_SUSP); // see R7

  // Power state transitions on CKE history
  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      LPSD_ST_ACTIVE: begin
        if (!mem.cke && cke_q_ff) begin
          if (busy_ff) nxt_pwr = LPSD_ST_SUSP; // see R7
          else if (cmd == LPSD_CMD_REF && all_idle) nxt_pwr = LPSD_ST_SREF; // see R20
          else if (is_nop) nxt_pwr = LPSD_ST_PDOWN; // see R3
        end
      end
      LPSD_ST_PDOWN: begin
        if (mem.cke && is_nop) nxt_pwr = LPSD_ST_ACTIVE; // see R6
        else if (!mem.cke && cmd == LPSD_CMD_BST) nxt_pwr = LPSD_ST_DPD; // see R15
      end
      LPSD_ST_SREF: if (mem.cke && is_nop) nxt_pwr = LPSD_ST_ACTIVE;
      LPSD_ST_DPD: if (mem.cke) nxt_pwr = LPSD_ST_ACTIVE; // see R16
      LPSD_ST_SUSP: if (mem.cke) nxt_pwr = LPSD_ST_ACTIVE; // see R9
      default: nxt_pwr = LPSD_ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_ff <= LPSD_ST_ACTIVE;
      cke_q_ff <= 1'b1;
    end else begin
      pwr_ff <= nxt_pwr;
      cke_q_ff <= mem.cke;
    end
  end

  // Commands only act on live, unsuspended edges with CKE high
  logic live;
  assign live = (pwr_ff == LPSD_ST_ACTIVE) && mem.cke && cke_q_ff; // see R8
  logic [BANKS-1:0] sel;
  assign sel = mem.addr[LPSD_ALL_BANKS_POS] ? '1 : (BANKS'(1) << mem.ba); // see R1
  logic acc;
  assign acc = live && (cmd == LPSD_CMD_RD || cmd == LPSD_CMD_WR);

  // Bank rows and precharge timers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      open_ff <= '0;
      ap_ff <= '0;
      pre_pend_ff <= '0;
      for (int i = 0; i < BANKS; i++) pre_cnt_ff[i] <= '0;
    end else begin
      for (int i = 0; i < BANKS; i++) begin
        if (pre_pend_ff[i]) begin
          if (pre_cnt_ff[i] == 4'h0) begin
            pre_pend_ff[i] <= 1'b0; // see R2
          end else begin
            pre_cnt_ff[i] <= pre_cnt_ff[i] - 4'h1;
          end
        end
      end
      if (live && cmd == LPSD_CMD_ACT && !pre_pend_ff[mem.ba]) open_ff[mem.ba] <= 1'b1; // see R2
      if (live && cmd == LPSD_CMD_PRE) begin
        for (int i = 0; i < BANKS; i++) begin
          if (sel[i]) begin
            open_ff[i] <= 1'b0;
            pre_pend_ff[i] <= 1'b1;
            pre_cnt_ff[i] <= 4'(LPSD_TRP_CYC - 1);
          end
        end
      end
      if (acc) ap_ff[mem.ba] <= mem.addr[LPSD_ALL_BANKS_POS];
      // New access to another bank cuts an auto-precharge burst
      if (acc && busy_ff && ap_ff[burst_bank_ff] && burst_bank_ff != mem.ba) begin
        open_ff[burst_bank_ff] <= 1'b0;
        pre_pend_ff[burst_bank_ff] <= 1'b1;
        ap_ff[burst_bank_ff] <= 1'b0;
        // Reads precharge now; writes wait out recovery first
        pre_cnt_ff[burst_bank_ff] <= rd_ff ? 4'(LPSD_TRP_CYC - 1) // see R11 see R12
                                           : 4'(LPSD_TWR_CYC + LPSD_TRP_CYC - 1); // see R13 see R14
      end else if (busy_ff && !suspended && burst_ff == 4'h1 && ap_ff[burst_bank_ff] && !acc) begin
        open_ff[burst_bank_ff] <= 1'b0;
        pre_pend_ff[burst_bank_ff] <= 1'b1;
        ap_ff[burst_bank_ff] <= 1'b0;
        pre_cnt_ff[burst_bank_ff] <= 4'(LPSD_TRP_CYC - 1);
      end
    end
  end

  // Mode register load, all banks idle only; a nonzero bank select
  // addresses the extended register, which must not clobber this one
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) mode_ff <= LPSD_MODE_RST;
    else if (live && cmd == LPSD_CMD_LMR && all_idle && mem.ba == 2'h0) mode_ff <= mem.addr; // see R19
  end

  // Burst tracker; counter frozen while suspended
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_ff <= 1'b0;
      rd_ff <= 1'b0;
      burst_ff <= '0;
      burst_bank_ff <= '0;
    end else if (acc && open_ff[mem.ba]) begin
      busy_ff <= 1'b1;
      rd_ff <= (cmd == LPSD_CMD_RD);
      burst_bank_ff <= mem.ba;
      // Single-column writes in burst-read/single-write mode
      burst_ff <= (cmd == LPSD_CMD_WR && mode_ff[LPSD_WBM_POS]) ? 4'h1 : burst_len(mode_ff[2:0]); // see R10
    end else if (live && cmd == LPSD_CMD_BST) begin
      busy_ff <= 1'b0;
    end else if (busy_ff && !suspended && cke_q_ff) begin // see R8
      burst_ff <= burst_ff - 4'h1;
      if (burst_ff == 4'h1) busy_ff <= 1'b0;
    end
  end

  // Write data capture; DQM masks, suspend ignores
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_valid_o <= 1'b0;
      wr_data_o <= '0;
      wr_bank_o <= '0;
    end else begin
      wr_valid_o <= 1'b0;
      // The command edge is the first beat, so the last counter step takes none
      if (live && ((acc && cmd == LPSD_CMD_WR) || (busy_ff && !rd_ff && burst_ff != 4'h1 && cmd != LPSD_CMD_RD
          && cmd != LPSD_CMD_WR && cmd != LPSD_CMD_BST)) && mem.dqm == 4'h0) begin // see R10
        wr_valid_o <= 1'b1;
        wr_data_o <= mem.dq_ctl;
        wr_bank_o <= acc ? mem.ba : burst_bank_ff;
      end
    end
  end

  // Read data pipeline at CAS latency; holds while suspended
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_lat_ff <= '0;
      dq_out_ff <= '0;
      dq_oe_ff <= 1'b0;
      for (int i = 0; i < 4; i++) rd_data_ff[i] <= '0;
    end else if (!suspended) begin
      rd_lat_ff <= {rd_lat_ff[2:0], busy_ff && rd_ff};
      rd_data_ff[0] <= {30'h0, burst_bank_ff};
      for (int i = 1; i < 4; i++) rd_data_ff[i] <= rd_data_ff[i-1];
      // CAS latency picks the tap; a new read replaces the old data
      dq_oe_ff <= rd_lat_ff[mode_ff[5:4] - 2'h1] && (pwr_ff == LPSD_ST_ACTIVE); // see R11
      dq_out_ff <= rd_data_ff[mode_ff[5:4] - 2'h1];
    end
  end

  assign mem.dq_mem = dq_out_ff;
  assign mem.dq_mem_oe = dq_oe_ff && in_buf_en_o;
  // Buffers off when asleep, CKE path stays on
  assign in_buf_en_o = (pwr_ff == LPSD_ST_ACTIVE) || (pwr_ff == LPSD_ST_SUSP); // see R4
  assign bank_open_o = open_ff;
  assign bank_pre_o = pre_pend_ff;
  assign pwr_state_o = pwr_ff;
endmodule : lpsd_mem
`default_nettype wire

// ===== rtl/lpsd_pkg.sv
package lpsd_pkg;
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] LPSD_CMD_NOP = 4'h7;
  localparam logic [3:0] LPSD_CMD_ACT = 4'h3;
  localparam logic [3:0] LPSD_CMD_RD = 4'h5;
  localparam logic [3:0] LPSD_CMD_WR = 4'h4;
  localparam logic [3:0] LPSD_CMD_PRE = 4'h2;
  localparam logic [3:0] LPSD_CMD_REF = 4'h1;
  localparam logic [3:0] LPSD_CMD_LMR = 4'h0;
  localparam logic [3:0] LPSD_CMD_BST = 4'h6;
  localparam logic [3:0] LPSD_CMD_INH = 4'h8;
  // Address bit positions
  localparam int LPSD_ALL_BANKS_POS = 10;
  localparam int LPSD_WBM_POS = 9;
  // Mode register reset value: burst 4, CAS latency 2
  localparam logic [12:0] LPSD_MODE_RST = 13'h0022;
  // Timings in ns or us and derived cycles at 4 ns
  localparam int LPSD_CLK_NS = 4;
  localparam int LPSD_TRP_NS = 18;
  localparam int LPSD_TRP_CYC = (LPSD_TRP_NS + LPSD_CLK_NS - 1) / LPSD_CLK_NS;
  localparam int LPSD_TWR_NS = 12;
  localparam int LPSD_TWR_CYC = (LPSD_TWR_NS + LPSD_CLK_NS - 1) / LPSD_CLK_NS;
  localparam int LPSD_TXSR_NS = 120;
  localparam int LPSD_TXSR_CYC = (LPSD_TXSR_NS + LPSD_CLK_NS - 1) / LPSD_CLK_NS;
  localparam int LPSD_TREF_US = 64000;
  localparam int LPSD_TREF_CYC = LPSD_TREF_US * 1000 / LPSD_CLK_NS;
  localparam int LPSD_DPD_MIN_US = 100;
  localparam int LPSD_DPD_CYC = LPSD_DPD_MIN_US * 1000 / LPSD_CLK_NS;
  localparam int LPSD_DPD_EXIT_US = 200;
  localparam int LPSD_DPDX_CYC = LPSD_DPD_EXIT_US * 1000 / LPSD_CLK_NS;
  localparam int LPSD_MIN_REFS = 2;
  localparam int LPSD_MIN_XSR_NOPS = 2;
  localparam int LPSD_DQM_LEAD = 2;
  // Device power states, Gray along the usual path
  typedef enum logic [2:0] {
    LPSD_ST_ACTIVE = 3'h0,
    LPSD_ST_PDOWN = 3'h1,
    LPSD_ST_SREF = 3'h3,
    LPSD_ST_DPD = 3'h2,
    LPSD_ST_SUSP = 3'h6
  } lpsd_pwr_type;
endpackage : lpsd_pkg

// ===== testbench/lpsd_chk.sv
`timescale 1ns/10ps
`default_nettype none
module lpsd_chk
  import lpsd_pkg::*;
#(
  parameter int DPD_CYC = 20,
  parameter int DPDX_CYC = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Link pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  input wire logic dq_mem_oe,
  // Device state
  input wire logic [3:0] bank_open_o,
  input wire logic [3:0] bank_pre_o,
  input wire logic [2:0] pwr_state_o,
  input wire logic in_buf_en_o
);
  logic [3:0] cmd;
  logic quiet;
  logic [31:0] dpd_cnt_ff;
  logic [31:0] wake_cnt_ff;
  // Decoded command; inhibit counts as quiet
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign quiet = cs_n || (cmd == LPSD_CMD_NOP);
  // Edges spent in deep power down
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dpd_cnt_ff <= 32'h0;
    end else begin
      dpd_cnt_ff <= (pwr_state_o == LPSD_ST_DPD) ? dpd_cnt_ff + 32'h1 : 32'h0;
    end
  end
  // Edges since deep power down; starts large so reset is not a wake
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_cnt_ff <= 32'h0010_0000;
    end else if (pwr_state_o == LPSD_ST_DPD) begin
      wake_cnt_ff <= 32'h0;
    end else if (wake_cnt_ff < 32'h0010_0000) begin
      wake_cnt_ff <= wake_cnt_ff + 32'h1;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence quiet_two;
    quiet ##1 quiet;
  endsequence
  a_pd_entry:
    assert property ($past(cke) && !cke && quiet && pwr_state_o == LPSD_ST_ACTIVE
      |=> pwr_state_o inside {LPSD_ST_PDOWN, LPSD_ST_SUSP}) else $error("no power-down entry");
  a_pd_bufs_off:
    assert property (pwr_state_o == LPSD_ST_PDOWN |-> !in_buf_en_o && !dq_mem_oe) else $error("buffers on");
  a_pd_exit:
    assert property (pwr_state_o == LPSD_ST_PDOWN && cke && quiet |=> pwr_state_o == LPSD_ST_ACTIVE)
      else $error("no power-down exit");
  a_low_hold:
    assert property (pwr_state_o inside {LPSD_ST_PDOWN, LPSD_ST_SREF, LPSD_ST_SUSP} && !cke
      && cmd != LPSD_CMD_BST |=> $stable(pwr_state_o)) else $error("low state left");
  a_sref_entry:
    assert property ($past(cke) && !cke && cmd == LPSD_CMD_REF && pwr_state_o == LPSD_ST_ACTIVE
      && bank_open_o == 4'h0 && bank_pre_o == 4'h0 |=> pwr_state_o == LPSD_ST_SREF) else $error("no self refresh");
  a_dpd_entry:
    assert property (pwr_state_o == LPSD_ST_PDOWN && !cke && cmd == LPSD_CMD_BST
      |=> pwr_state_o == LPSD_ST_DPD) else $error("no deep power down");
  a_dpd_min:
    assert property (pwr_state_o == LPSD_ST_DPD && cke |-> dpd_cnt_ff >= DPD_CYC - 2)
      else $error("deep power down too short");
  a_wake_nops:
    assert property (wake_cnt_ff < DPDX_CYC - 2 |-> quiet) else $error("command during wake");
  a_xsr_quiet:
    assert property (pwr_state_o == LPSD_ST_SREF && cke |-> quiet_two) else $error("command in exit");
  a_pre_all:
    assert property (cke && $past(cke) && pwr_state_o == LPSD_ST_ACTIVE && cmd == LPSD_CMD_PRE
      && addr[LPSD_ALL_BANKS_POS] |=> bank_open_o == 4'h0) else $error("banks left open");
  a_pre_one:
    assert property (cke && $past(cke) && pwr_state_o == LPSD_ST_ACTIVE && cmd == LPSD_CMD_PRE
      && !addr[LPSD_ALL_BANKS_POS] |=> bank_open_o == ($past(bank_open_o) & ~(4'h1 << $past(ba))))
      else $error("wrong bank closed");
endmodule // lpsd_chk
`default_nettype wire

// ===== testbench/tb_lp_sdram_power_precharge_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_lp_sdram_power_precharge_ctrl;
  import lpsd_pkg::*;
  // Shortened counts keep the run brief
  localparam int REF_C = 50;
  localparam int DPD_C = 20;
  logic clk_i, arst_n_i, req_i, req_cke_i, req_ready_o, rd_valid_o, wr_valid_o, in_buf_en_o;
  logic [3:0] req_cmd_i, req_dqm_i, bank_open_o, bank_pre_o;
  logic [1:0] req_ba_i, wr_bank_o;
  logic [12:0] req_addr_i;
  logic [31:0] req_data_i, rd_data_o, wr_data_o, seed, r;
  logic [2:0] pwr_state_o;
  logic [33:0] w;
  logic [33:0] wq[$];
  logic [31:0] rq[$];
  int fails = 0;
  int num_checks = 0;
  int n;
  lpsd_if link ();
  lpsd_ctrl #(.REF_CYC(REF_C), .DPD_CYC(DPD_C), .DPDX_CYC(DPD_C)) lpsd_ctrl_inst (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .req_i(req_i), .req_cmd_i(req_cmd_i), .req_ba_i(req_ba_i), .req_addr_i(req_addr_i),
    .req_dqm_i(req_dqm_i), .req_data_i(req_data_i), .req_cke_i(req_cke_i), .req_ready_o(req_ready_o),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .mem(link.ctrl));
  lpsd_mem #(.BANKS(4)) lpsd_mem_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .mem(link.mem),
    .bank_open_o(bank_open_o), .bank_pre_o(bank_pre_o), .pwr_state_o(pwr_state_o), .in_buf_en_o(in_buf_en_o),
    .wr_data_o(wr_data_o), .wr_bank_o(wr_bank_o), .wr_valid_o(wr_valid_o));
  lpsd_chk #(.DPD_CYC(DPD_C), .DPDX_CYC(DPD_C)) lpsd_chk_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
    .addr(link.addr), .dq_mem_oe(link.dq_mem_oe), .bank_open_o(bank_open_o), .pwr_state_o(pwr_state_o),
    .bank_pre_o(bank_pre_o), .in_buf_en_o(in_buf_en_o));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One request held until taken; req_i stays up so calls chain
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic k);
    int i;
    for (i = 0; i < 200 && req_ready_o !== 1'b1; i++) begin
      @(negedge clk_i);
    end
    if (i == 200) begin
      fails++;
      stop_test();
    end
    seed = xs(seed);
    req_i = 1'b1;
    req_cmd_i = c;
    req_ba_i = b;
    req_addr_i = a;
    req_data_i = seed;
    req_cke_i = k;
    if (c == LPSD_CMD_WR) begin
      wq.push_back({b, seed});
    end
    if (c == LPSD_CMD_RD) begin
      repeat (4) rq.push_back({30'h0, b});
    end
    @(negedge clk_i);
  endtask
  task automatic gap(input int c);
    req_i = 1'b0;
    repeat (c) @(negedge clk_i);
  endtask
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    stop_test();
  end
  // Results sampled mid-cycle, paired with the oldest note
  always @(negedge clk_i) begin
    if (wr_valid_o === 1'b1) begin
      w = (wq.size() > 0) ? wq.pop_front() : '1;
      `CHK("write", w, {wr_bank_o, wr_data_o})
    end
    if (rd_valid_o === 1'b1) begin
      r = (rq.size() > 0) ? rq.pop_front() : '1;
      `CHK("read", r, rd_data_o)
    end
  end
  initial begin
    arst_n_i = 1'b0;
    req_i = 1'b0;
    req_cmd_i = LPSD_CMD_NOP;
    req_ba_i = 2'h0;
    req_addr_i = 13'h0000;
    req_dqm_i = 4'h0;
    req_data_i = 32'h0;
    req_cke_i = 1'b1;
    seed = 32'h24;
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    // Single-write mode, then back-to-back writes and a read per bank
    issue(LPSD_CMD_LMR, 2'h0, 13'h0222, 1'b1);
    gap(3);
    for (int b = 0; b < 4; b++) begin
      issue(LPSD_CMD_ACT, 2'(b), 13'h0000, 1'b1);
      gap(3);
      issue(LPSD_CMD_WR, 2'(b), 13'h0000, 1'b1);
      issue(LPSD_CMD_WR, 2'(b), 13'h0004, 1'b1);
      issue(LPSD_CMD_RD, 2'(b), 13'h0000, 1'b1);
      gap(8);
    end
    `CHK("open", 4'hf, bank_open_o)
    $display("test access done");
    issue(LPSD_CMD_PRE, 2'h1, 13'h0000, 1'b1);
    gap(2);
    `CHK("pre one", 4'hd, bank_open_o)
    issue(LPSD_CMD_PRE, 2'h1, 13'h0400, 1'b1);
    gap(4);
    `CHK("pre all", 4'h0, bank_open_o)
    $display("test precharge done");
    // Active then precharge power-down
    for (int j = 0; j < 2; j++) begin
      if (j == 0) begin
        // Precharge time must pass before the row is opened again
        gap(2);
        issue(LPSD_CMD_ACT, 2'h2, 13'h0000, 1'b1);
        gap(3);
      end else begin
        issue(LPSD_CMD_PRE, 2'h0, 13'h0400, 1'b1);
        gap(4);
      end
      issue(LPSD_CMD_NOP, 2'h0, 13'h0000, 1'b0);
      gap(3);
      `CHK("pd", LPSD_ST_PDOWN, pwr_state_o)
      `CHK("pd rows", (j == 0) ? 4'h4 : 4'h0, bank_open_o)
      `CHK("buf", 1'b0, in_buf_en_o)
      issue(LPSD_CMD_NOP, 2'h0, 13'h0000, 1'b1);
      gap(2);
      `CHK("pd exit", LPSD_ST_ACTIVE, pwr_state_o)
    end
    // Power-down left alone must end before the refresh period
    issue(LPSD_CMD_NOP, 2'h0, 13'h0000, 1'b0);
    gap(3);
    for (n = 0; n < 300 && pwr_state_o !== LPSD_ST_ACTIVE; n++) begin
      @(negedge clk_i);
    end
    `CHK("pd limit", 1'b1, n > 0 && n + 3 <= REF_C)
    $display("test power-down done");
    issue(LPSD_CMD_REF, 2'h0, 13'h0000, 1'b0);
    gap(6);
    `CHK("sref", LPSD_ST_SREF, pwr_state_o)
    issue(LPSD_CMD_NOP, 2'h0, 13'h0000, 1'b1);
    issue(LPSD_CMD_PRE, 2'h0, 13'h0400, 1'b1);
    gap(4);
    `CHK("sref exit", LPSD_ST_ACTIVE, pwr_state_o)
    $display("test self refresh done");
    issue(LPSD_CMD_NOP, 2'h0, 13'h0000, 1'b0);
    gap(2);
    issue(LPSD_CMD_BST, 2'h0, 13'h0000, 1'b0);
    gap(3);
    `CHK("dpd", LPSD_ST_DPD, pwr_state_o)
    issue(LPSD_CMD_NOP, 2'h0, 13'h0000, 1'b1);
    // Wake-up sequence, then prove the device serves a write
    issue(LPSD_CMD_PRE, 2'h0, 13'h0400, 1'b1);
    gap(4);
    issue(LPSD_CMD_REF, 2'h0, 13'h0000, 1'b1);
    gap(8);
    issue(LPSD_CMD_REF, 2'h0, 13'h0000, 1'b1);
    gap(8);
    issue(LPSD_CMD_LMR, 2'h0, 13'h0222, 1'b1);
    gap(3);
    issue(LPSD_CMD_LMR, 2'h2, 13'h0000, 1'b1);
    gap(3);
    issue(LPSD_CMD_ACT, 2'h1, 13'h0000, 1'b1);
    gap(3);
    issue(LPSD_CMD_WR, 2'h1, 13'h0008, 1'b1);
    gap(10);
    `CHK("dpd exit", LPSD_ST_ACTIVE, pwr_state_o)
    `CHK("notes left", 0, wq.size() + rq.size())
    $display("test deep power down done");
    stop_test();
  end
endmodule // tb_lp_sdram_power_precharge_ctrl
`default_nettype wire
